// file: common/charge_state_regs.vh
`ifndef CHARGE_STATE_REGS_VH
`define CHARGE_STATE_REGS_VH

// ****************************************
// register map (word byte addresses)
// ****************************************
`define CSC_ADDR_CTRL      4'h0
`define CSC_ADDR_STATUS    4'h4
`define CSC_ADDR_ZONE      4'h8
`define CSC_ADDR_COMP      4'hC

// ****************************************
// control register fields
// ****************************************
`define CSC_CTRL_TRACK_BIT 0
`define CSC_CTRL_RESET     32'h0000_0000
`define CSC_CTRL_TRACK_RESET 1'b0

// ****************************************
// charger states
// ****************************************
`define CSC_ST_SLEEP       3'h0
`define CSC_ST_TRICKLE     3'h1
`define CSC_ST_CC          3'h2
`define CSC_ST_CV          3'h3
`define CSC_ST_DONE        3'h4
`define CSC_ST_SUSPEND     3'h5
`define CSC_ST_OVP         3'h6

// ****************************************
// temperature zones
// ****************************************
`define CSC_Z_NORMAL       3'h0
`define CSC_Z_COOL         3'h1
`define CSC_Z_COLD         3'h2
`define CSC_Z_WARM         3'h3
`define CSC_Z_HOT          3'h4

// ****************************************
// current scale and voltage scale codes
// ****************************************
`define CSC_I_FULL         2'h0
`define CSC_I_HALF         2'h1
`define CSC_I_QUARTER      2'h2
`define CSC_I_OFF          2'h3
`define CSC_V_NOMINAL      1'b0
`define CSC_V_REDUCED      1'b1

// ****************************************
// comparator sync depth
// ****************************************
`define CSC_SYNC_STAGES    2

`endif

// file: rtl/charge_state_controller.v
// Operation
// - in constant voltage, end the cycle when current falls to 15% of full scale
// - when done, charging indicator released, completion indicator pulled low
// - when done, both high-side and low-side drives are off
// - under solar tracking, end only if battery above 95.8% and current below 15%
// - after done, with supply and battery present, restart below 95.8% of target
// - classify battery temperature into hot, warm, normal, cool or cold continuously
// - normal zone uses full current and nominal regulation target
// - cool zone limits current to 25% and keeps nominal target
// - warm zone limits current to 50% and lowers target to 97.91%
// - hot or cold suspends charging, both indicators released
// - charging resumes by itself once neither hot nor cold
// - zones use separate entry and release thresholds, hysteresis both ends
// - charging indicator low while actively charging, released otherwise
// - without battery, cycle between charge and done or over-voltage modes
// - both indicators released under lockout, input not above battery, or hot/cold
// - supply absent or below battery: sleep, blocking gate to battery, switch off
// - outside sleep the reverse blocking switch stays on
// - below 66.6% at start, trickle at 25%, then constant current
// - start only with input above lockout and above battery by release margin
// - above 6.8% overshoot, both switches off until condition clears
//
// Chosen here: the Wishbone slave port and the register offsets.
`include "charge_state_regs.vh"

module charge_state_controller (
	input  wire        clk_i,
	input  wire        rst_i,
	// supply and battery comparators
	input  wire        vin_above_lockout_i,
	input  wire        vin_above_battery_i,
	input  wire        vin_above_release_i,
	input  wire        battery_present_i,
	input  wire        bat_above_trickle_i,
	input  wire        bat_near_target_i,
	input  wire        bat_above_recharge_i,
	input  wire        bat_over_voltage_i,
	input  wire        current_below_term_i,
	// thermistor comparators
	input  wire        below_hot_i,
	input  wire        above_hot_release_i,
	input  wire        below_warm_i,
	input  wire        above_warm_release_i,
	input  wire        above_cool_i,
	input  wire        below_cool_release_i,
	input  wire        above_cold_i,
	input  wire        below_cold_release_i,
	// classic wishbone slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [3:0]  adr_i,
	input  wire [31:0] dat_i,
	input  wire [3:0]  sel_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	// power stage
	output reg         high_side_en_o,
	output reg         low_side_en_o,
	output reg  [1:0]  current_scale_o,
	output reg         target_reduced_o,
	output reg         solar_tracking_o,
	output reg         reverse_block_gate_o,
	// open-drain indicators: oe low means pin pulled low
	output reg         charging_indicator_n_o,
	output reg         charging_indicator_n_oe_o,
	output reg         done_indicator_n_o,
	output reg         done_indicator_n_oe_o
);

	localparam NCMP = 17;

	// ****************************************
	// comparator synchronisers
	// ****************************************
	wire [NCMP-1:0] raw_cmp;
	reg  [NCMP-1:0] sync1_ff;
	reg  [NCMP-1:0] sync2_ff;

	assign raw_cmp = {vin_above_lockout_i, vin_above_battery_i, vin_above_release_i,
			battery_present_i, bat_above_trickle_i, bat_near_target_i,
			bat_above_recharge_i, bat_over_voltage_i, current_below_term_i,
			below_hot_i, above_hot_release_i, below_warm_i, above_warm_release_i,
			above_cool_i, below_cool_release_i, above_cold_i, below_cold_release_i};

	// two stages, first stage feeds only the second
	always @(posedge clk_i) begin
		if (rst_i) begin
			sync1_ff <= {NCMP{1'b0}};
			sync2_ff <= {NCMP{1'b0}};
		end else begin
			sync1_ff <= raw_cmp;
			sync2_ff <= sync1_ff;
		end
	end

	wire s_lockout_ok  = sync2_ff[16];
	wire s_vin_gt_bat  = sync2_ff[15];
	wire s_vin_release = sync2_ff[14];
	wire s_bat_present = sync2_ff[13];
	wire s_above_trk   = sync2_ff[12];
	wire s_near_target = sync2_ff[11];
	wire s_above_rchg  = sync2_ff[10];
	wire s_ovp         = sync2_ff[9];
	wire s_i_low       = sync2_ff[8];

	// ****************************************
	// temperature zones
	// ****************************************
	wire [2:0] zone;

	temp_zone_classifier u_zone (
		.clk_i                (clk_i),
		.rst_i                (rst_i),
		.below_hot_i          (sync2_ff[7]),
		.above_hot_release_i  (sync2_ff[6]),
		.below_warm_i         (sync2_ff[5]),
		.above_warm_release_i (sync2_ff[4]),
		.above_cool_i         (sync2_ff[3]),
		.below_cool_release_i (sync2_ff[2]),
		.above_cold_i         (sync2_ff[1]),
		.below_cold_release_i (sync2_ff[0]),
		.zone_ff              (zone)
	);

	wire temp_bad = (zone == `CSC_Z_HOT) || (zone == `CSC_Z_COLD);

	// ****************************************
	// control register
	// ****************************************
	reg         track_ff;
	wire        wb_hit = cyc_i & stb_i & ~ack_o;
	wire        wb_wr  = wb_hit & we_i;

	// software selects solar tracking termination
	always @(posedge clk_i) begin
		if (rst_i)
			track_ff <= `CSC_CTRL_TRACK_RESET;
		else if (wb_wr && adr_i == `CSC_ADDR_CTRL && sel_i[0])
			track_ff <= dat_i[`CSC_CTRL_TRACK_BIT];
	end

	// ****************************************
	// charge state machine
	// ****************************************
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg       cycle_done_ff;

	// supply present enough to stay awake
	wire awake_ok = s_lockout_ok & s_vin_gt_bat;
	// stricter start condition from sleep
	wire start_ok = s_lockout_ok & s_vin_release;
	// termination test, tighter under solar tracking
	wire term_ok  = s_i_low & (~track_ff | s_above_rchg);

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			`CSC_ST_SLEEP: begin
				if (start_ok)
					nxt_state = temp_bad ? `CSC_ST_SUSPEND :
						(s_above_trk ? `CSC_ST_CC : `CSC_ST_TRICKLE);
			end
			`CSC_ST_TRICKLE: begin
				if (s_above_trk)
					nxt_state = `CSC_ST_CC;
			end
			`CSC_ST_CC: begin
				if (s_near_target)
					nxt_state = `CSC_ST_CV;
			end
			`CSC_ST_CV: begin
				if (term_ok)
					nxt_state = `CSC_ST_DONE;
			end
			`CSC_ST_DONE: begin
				if (s_bat_present && !s_above_rchg)
					nxt_state = s_above_trk ? `CSC_ST_CC : `CSC_ST_TRICKLE;
				else if (!s_bat_present && !s_above_rchg)
					nxt_state = `CSC_ST_CC;
			end
			`CSC_ST_SUSPEND: begin
				if (!temp_bad)
					nxt_state = cycle_done_ff ? `CSC_ST_DONE :
						(s_above_trk ? `CSC_ST_CC : `CSC_ST_TRICKLE);
			end
			`CSC_ST_OVP: begin
				if (!s_ovp)
					nxt_state = s_near_target ? `CSC_ST_CV : `CSC_ST_CC;
			end
			default: begin
				nxt_state = `CSC_ST_SLEEP;
			end
		endcase
		// overriding conditions, supply loss first
		if (state_ff != `CSC_ST_SLEEP) begin
			if (!awake_ok)
				nxt_state = `CSC_ST_SLEEP;
			else if (temp_bad)
				nxt_state = `CSC_ST_SUSPEND;
			else if (s_ovp)
				nxt_state = `CSC_ST_OVP;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i)
			state_ff <= `CSC_ST_SLEEP;
		else
			state_ff <= nxt_state;
	end

	// remembers a finished cycle across a suspension
	always @(posedge clk_i) begin
		if (rst_i)
			cycle_done_ff <= 1'b0;
		else if (nxt_state == `CSC_ST_DONE)
			cycle_done_ff <= 1'b1;
		else if (nxt_state != `CSC_ST_SUSPEND)
			cycle_done_ff <= 1'b0;
	end

	// ****************************************
	// output decode
	// ****************************************
	wire charging = (nxt_state == `CSC_ST_TRICKLE) || (nxt_state == `CSC_ST_CC) ||
			(nxt_state == `CSC_ST_CV);

	// current scale from state and zone
	function [1:0] scale_of;
		input [2:0] st;
		input [2:0] zn;
		begin
			if (st == `CSC_ST_TRICKLE)
				scale_of = `CSC_I_QUARTER;
			else if (zn == `CSC_Z_COOL)
				scale_of = `CSC_I_QUARTER;
			else if (zn == `CSC_Z_WARM)
				scale_of = `CSC_I_HALF;
			else
				scale_of = `CSC_I_FULL;
		end
	endfunction

	// registered power and indicator outputs
	always @(posedge clk_i) begin
		if (rst_i) begin
			high_side_en_o            <= 1'b0;
			low_side_en_o             <= 1'b0;
			current_scale_o           <= `CSC_I_OFF;
			target_reduced_o          <= `CSC_V_NOMINAL;
			solar_tracking_o          <= 1'b0;
			reverse_block_gate_o      <= 1'b1;
			charging_indicator_n_o    <= 1'b0;
			charging_indicator_n_oe_o <= 1'b1;
			done_indicator_n_o        <= 1'b0;
			done_indicator_n_oe_o     <= 1'b1;
		end else begin
			high_side_en_o   <= charging;
			low_side_en_o    <= charging;
			current_scale_o  <= charging ? scale_of(nxt_state, zone) : `CSC_I_OFF;
			target_reduced_o <= (zone == `CSC_Z_WARM);
			solar_tracking_o <= track_ff;
			// gate high blocks the switch in sleep, low keeps it on otherwise
			reverse_block_gate_o <= (nxt_state == `CSC_ST_SLEEP);
			charging_indicator_n_o    <= 1'b0;
			charging_indicator_n_oe_o <= ~charging;
			done_indicator_n_o        <= 1'b0;
			done_indicator_n_oe_o     <= (nxt_state != `CSC_ST_DONE);
		end
	end

	// ****************************************
	// wishbone read and ack
	// ****************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= wb_hit;
			dat_o <= 32'h0000_0000;
			if (wb_hit && !we_i) begin
				case (adr_i)
					`CSC_ADDR_CTRL:   dat_o <= {31'h0000_0000, track_ff};
					`CSC_ADDR_STATUS: dat_o <= {29'h0000_0000, state_ff};
					`CSC_ADDR_ZONE:   dat_o <= {29'h0000_0000, zone};
					`CSC_ADDR_COMP:   dat_o <= {15'h0000, sync2_ff};
					default:          dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

// file: rtl/temp_zone_classifier.v
`include "charge_state_regs.vh"

module temp_zone_classifier (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       below_hot_i,
	input  wire       above_hot_release_i,
	input  wire       below_warm_i,
	input  wire       above_warm_release_i,
	input  wire       above_cool_i,
	input  wire       below_cool_release_i,
	input  wire       above_cold_i,
	input  wire       below_cold_release_i,
	output reg  [2:0] zone_ff
);

	reg [2:0] nxt_zone;

	// ****************************************
	// hysteretic zone walk
	// ****************************************
	// zones step through neighbours; entry and release use separate compares
	always @* begin
		nxt_zone = zone_ff;
		case (zone_ff)
			`CSC_Z_NORMAL: begin
				if (below_warm_i)
					nxt_zone = `CSC_Z_WARM;
				else if (above_cool_i)
					nxt_zone = `CSC_Z_COOL;
			end
			`CSC_Z_WARM: begin
				if (below_hot_i)
					nxt_zone = `CSC_Z_HOT;
				else if (above_warm_release_i)
					nxt_zone = `CSC_Z_NORMAL;
			end
			`CSC_Z_HOT: begin
				if (above_hot_release_i)
					nxt_zone = `CSC_Z_WARM;
			end
			`CSC_Z_COOL: begin
				if (above_cold_i)
					nxt_zone = `CSC_Z_COLD;
				else if (below_cool_release_i)
					nxt_zone = `CSC_Z_NORMAL;
			end
			`CSC_Z_COLD: begin
				if (below_cold_release_i)
					nxt_zone = `CSC_Z_COOL;
			end
			default: begin
				nxt_zone = `CSC_Z_NORMAL;
			end
		endcase
	end

	// zone register, continuously updated
	always @(posedge clk_i) begin
		if (rst_i)
			zone_ff <= `CSC_Z_NORMAL;
		else
			zone_ff <= nxt_zone;
	end

endmodule

// file: testbench/charge_state_controller_monitor.sv
`include "charge_state_regs.vh"

// ****
// output relation checker
// ****
module charge_state_controller_monitor (
	input logic       clk_i,
	input logic       rst_i,
	input logic       cyc_i,
	input logic       stb_i,
	input logic       ack_o,
	input logic       vin_above_lockout_i,
	input logic       vin_above_battery_i,
	input logic       bat_above_recharge_i,
	input logic       bat_over_voltage_i,
	input logic       below_hot_i,
	input logic       below_warm_i,
	input logic       high_side_en_o,
	input logic       low_side_en_o,
	input logic [1:0] current_scale_o,
	input logic       target_reduced_o,
	input logic       solar_tracking_o,
	input logic       reverse_block_gate_o,
	input logic       charging_indicator_n_oe_o,
	input logic       done_indicator_n_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// one clock domain, reset masks all but the reset check
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_ack;
		cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack not one cycle");

	property p_done;
		!done_indicator_n_oe_o |-> charging_indicator_n_oe_o && !high_side_en_o && !low_side_en_o;
	endproperty
	a_done: assert property (p_done) else $error("done with drive or charging");

	property p_chg;
		!charging_indicator_n_oe_o |-> done_indicator_n_oe_o && !reverse_block_gate_o;
	endproperty
	a_chg: assert property (p_chg) else $error("charging with switch off");

	property p_gate;
		reverse_block_gate_o |-> charging_indicator_n_oe_o && done_indicator_n_oe_o
			&& !high_side_en_o;
	endproperty
	a_gate: assert property (p_gate) else $error("sleep not quiet");

	property p_sleep;
		!vin_above_battery_i [*5] |=> reverse_block_gate_o;
	endproperty
	a_sleep: assert property (p_sleep) else $error("no sleep on low input");

	property p_lockout;
		!vin_above_lockout_i [*5] |=> charging_indicator_n_oe_o && done_indicator_n_oe_o;
	endproperty
	a_lockout: assert property (p_lockout) else $error("indicator in lockout");

	property p_ovp;
		bat_over_voltage_i [*5] |=> !high_side_en_o && !low_side_en_o;
	endproperty
	a_ovp: assert property (p_ovp) else $error("drive on in over voltage");

	property p_hot;
		(below_hot_i && below_warm_i) [*8] |=> charging_indicator_n_oe_o
			&& done_indicator_n_oe_o && !high_side_en_o;
	endproperty
	a_hot: assert property (p_hot) else $error("charging while hot");

	property p_warm;
		target_reduced_o |-> current_scale_o != `CSC_I_FULL;
	endproperty
	a_warm: assert property (p_warm) else $error("reduced target at full current");

	property p_solar;
		(solar_tracking_o && !bat_above_recharge_i) [*5] |=> done_indicator_n_oe_o;
	endproperty
	a_solar: assert property (p_solar) else $error("done below recharge level");

	property p_reset;
		@(posedge clk_i) disable iff (1'b0) rst_i |=> reverse_block_gate_o
			&& charging_indicator_n_oe_o && done_indicator_n_oe_o && !high_side_en_o;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule

bind charge_state_controller charge_state_controller_monitor mon (.clk_i, .rst_i, .cyc_i,
	.stb_i, .ack_o, .vin_above_lockout_i, .vin_above_battery_i, .bat_above_recharge_i,
	.bat_over_voltage_i, .below_hot_i, .below_warm_i, .high_side_en_o, .low_side_en_o,
	.current_scale_o, .target_reduced_o, .solar_tracking_o, .reverse_block_gate_o,
	.charging_indicator_n_oe_o, .done_indicator_n_oe_o);

// file: testbench/power_stage_model.sv
// ****
// analog stage, battery and thermistor
// ****
module power_stage_model #(
	parameter int LOCKOUT_PM = 400,
	parameter int MARGIN_PM  = 20,
	parameter int NEAR_PM    = 940
) (
	input  int         vin_pm_i,
	input  int         bat_pm_i,
	input  int         cur_pm_i,
	input  int         temp_mv_i,
	input  logic       bat_in_i,
	input  logic       high_side_en_i,
	output logic [8:0] supply_cmp_o,
	output logic [7:0] temp_cmp_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int cur;

	// sensed current collapses once the high side stops
	assign cur = high_side_en_i ? cur_pm_i : 0;
	// supply and battery compares, per mille of target
	assign supply_cmp_o = {vin_pm_i > LOCKOUT_PM, vin_pm_i > bat_pm_i,
		vin_pm_i > bat_pm_i + MARGIN_PM, bat_in_i, bat_pm_i > 666, bat_pm_i > NEAR_PM,
		bat_pm_i > 958, bat_pm_i > 1068, cur < 150};
	// thermistor compares in millivolts
	assign temp_cmp_o = {temp_mv_i < 100, temp_mv_i > 120, temp_mv_i < 135, temp_mv_i > 155,
		temp_mv_i > 550, temp_mv_i < 505, temp_mv_i > 850, temp_mv_i < 805};
endmodule

// file: testbench/tb_charge_state_controller.sv
`include "charge_state_regs.vh"

module tb_charge_state_controller;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, rdv;
	logic        ack_o, high_side_en_o, low_side_en_o, target_reduced_o, solar_tracking_o;
	logic        reverse_block_gate_o, charging_indicator_n_o, charging_indicator_n_oe_o;
	logic        done_indicator_n_o, done_indicator_n_oe_o;
	logic [1:0]  current_scale_o, ind, drv;
	logic        vin_above_lockout_i, vin_above_battery_i, vin_above_release_i;
	logic        battery_present_i, bat_above_trickle_i, bat_near_target_i;
	logic        bat_above_recharge_i, bat_over_voltage_i, current_below_term_i;
	logic        below_hot_i, above_hot_release_i, below_warm_i, above_warm_release_i;
	logic        above_cool_i, below_cool_release_i, above_cold_i, below_cold_release_i;
	logic [8:0]  supply_cmp;
	logic [7:0]  temp_cmp;
	logic        bat_in = 1'b1;
	int          vin_pm = 1500, bat_pm = 500, cur_pm = 500, temp_mv = 300;
	int          err_count = 0, compares = 0;

	// ****
	// clock, model, design
	// ****
	always #2.5 clk_i = ~clk_i;
	assign {vin_above_lockout_i, vin_above_battery_i, vin_above_release_i, battery_present_i,
		bat_above_trickle_i, bat_near_target_i, bat_above_recharge_i, bat_over_voltage_i,
		current_below_term_i} = supply_cmp;
	assign {below_hot_i, above_hot_release_i, below_warm_i, above_warm_release_i, above_cool_i,
		below_cool_release_i, above_cold_i, below_cold_release_i} = temp_cmp;
	assign ind = {charging_indicator_n_oe_o, done_indicator_n_oe_o};
	assign drv = {high_side_en_o, low_side_en_o};
	power_stage_model psm (.vin_pm_i(vin_pm), .bat_pm_i(bat_pm), .cur_pm_i(cur_pm),
		.temp_mv_i(temp_mv), .bat_in_i(bat_in), .high_side_en_i(high_side_en_o),
		.supply_cmp_o(supply_cmp), .temp_cmp_o(temp_cmp));
	charge_state_controller dut (.*);

	// ****
	// shared tasks
	// ****
	task end_of_test;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask

	// single bus cycle held until ack
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rdv = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task rdchk(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask

	task settle;
		repeat (10) @(posedge clk_i);
	endtask

	// ****
	// scenarios
	// ****
	task t_charge;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h1);
		chk({ind, current_scale_o, reverse_block_gate_o}, 5'h0C);
		bat_pm <= 800;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h2);
		chk({ind, current_scale_o, target_reduced_o}, 5'h08);
		bat_pm <= 990;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h3);
		cur_pm <= 100;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h4);
		chk({ind, drv}, 4'h8);
		bat_pm <= 900;
		cur_pm <= 500;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h2);
	endtask

	task t_solar;
		wb(1'b1, `CSC_ADDR_CTRL, 32'h1);
		chk(solar_tracking_o, 32'h1);
		rdchk(`CSC_ADDR_CTRL, 32'h1);
		bat_pm <= 950;
		cur_pm <= 100;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h3);
		bat_pm <= 970;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h4);
		wb(1'b1, `CSC_ADDR_CTRL, 32'h0);
		bat_pm <= 900;
		cur_pm <= 500;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h2);
	endtask

	task t_zone;
		int         tv[12] = '{130, 145, 200, 90, 110, 130, 200, 600, 530, 900, 820, 300};
		logic [2:0] zv[12] = '{3'h3, 3'h3, 3'h0, 3'h4, 3'h4, 3'h3, 3'h0, 3'h1, 3'h1, 3'h2,
			3'h2, 3'h0};
		for (int i = 0; i < 12; i++) begin
			temp_mv <= tv[i];
			settle();
			rdchk(`CSC_ADDR_ZONE, {29'h0, zv[i]});
			if (zv[i] == 3'h2 || zv[i] == 3'h4) begin
				chk({ind, drv}, 4'hC);
			end else begin
				chk({ind, current_scale_o, target_reduced_o}, {2'h1, zv[i] == 3'h1 ? 2'h2 :
					{1'b0, zv[i] == 3'h3}, zv[i] == 3'h3});
			end
		end
	endtask

	task t_ovp;
		bat_pm <= 1100;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h6);
		chk(drv, 32'h0);
		bat_pm <= 900;
		settle();
		chk(ind, 32'h1);
	endtask

	// battery pulled away after a finished cycle
	task t_nobat;
		bat_pm <= 990;
		cur_pm <= 100;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h4);
		bat_in <= 1'b0;
		bat_pm <= 500;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h2);
		bat_pm <= 990;
		settle();
		chk({ind, drv}, 4'h8);
		chk({charging_indicator_n_o, done_indicator_n_o}, 2'h0);
		bat_in <= 1'b1;
		bat_pm <= 900;
		cur_pm <= 500;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h2);
	endtask

	task t_sleep;
		vin_pm <= 300;
		settle();
		chk({ind, reverse_block_gate_o}, 3'h7);
		vin_pm <= 700;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h0);
		vin_pm <= 910;
		settle();
		rdchk(`CSC_ADDR_STATUS, 32'h0);
		vin_pm <= 1500;
		settle();
		chk({ind, reverse_block_gate_o}, 3'h2);
		rdchk(`CSC_ADDR_COMP, 32'h0001_F055);
	endtask

	// ****
	// main sequence and watchdog
	// ****
	initial begin
		repeat (4) @(posedge clk_i);
		chk({reverse_block_gate_o, ind, drv, current_scale_o}, 7'h73);
		rst_i <= 1'b0;
		rdchk(`CSC_ADDR_CTRL, 32'h0);
		rdchk(4'h2, 32'h0);
		t_charge();
		t_solar();
		t_zone();
		t_ovp();
		t_nobat();
		t_sleep();
		end_of_test();
	end

	initial begin
		#100000;
		err_count++;
		end_of_test();
	end
endmodule
